// >>> hrc_ctl.sv
// Embedded controller end: ring storage and firmware registers over AHB-Lite
`timescale 1ns/1ps
`default_nettype none
module hrc_ctl (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Controller link
	hrc_if.ctl link,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp
);
	// Ring storage
	logic [31:0] ring_mem [0:hrc_pkg::RING_MAX-1];
	// Register state
	logic [9:0] cfg_q;
	logic [9:0] cfg_d;
	logic consume_q;
	logic ph_q;
	logic ph_wr_q;
	logic [3:0] ph_addr_q;
	logic hreadyout_q;
	logic [31:0] hrdata_q;
	logic [31:0] rdata_d;

	// Address phase and data phase decode
	wire accept = hsel & hready & (htrans == hrc_pkg::HTRANS_NONSEQ);
	wire wr_cfg = ph_q & ph_wr_q & (ph_addr_q == hrc_pkg::CTL_OFF_CFG);
	wire wr_pop = ph_q & ph_wr_q & (ph_addr_q == hrc_pkg::CTL_OFF_POP);
	wire ring_empty = (link.rd_ptr == link.wr_ptr);
	wire pop = wr_pop & ~ring_empty;
	wire [31:0] stat_val = {15'h0000, link.host_rdy, link.rd_ptr, link.wr_ptr};
	wire [31:0] cfg_val = {22'h000000, cfg_q};
	wire [31:0] data_val = ring_mem[link.rd_ptr[hrc_pkg::RING_AW-1:0]];
	wire rdy_set = wr_cfg & hwdata[hrc_pkg::CFG_RDY_BIT];

	// Ring reset clears ready unless firmware sets it in the same cycle
	always_comb begin
		cfg_d = cfg_q;
		if (wr_cfg) begin
			cfg_d = hwdata[9:0];
		end
		if (link.ring_reset && !rdy_set) begin
			cfg_d[hrc_pkg::CFG_RDY_BIT] = 1'h0;
		end
	end

	always_comb begin
		unique case (ph_addr_q)
			hrc_pkg::CTL_OFF_CFG: rdata_d = cfg_val;
			hrc_pkg::CTL_OFF_STAT: rdata_d = stat_val;
			hrc_pkg::CTL_OFF_DATA: rdata_d = data_val;
			default: rdata_d = 32'h00000000;
		endcase
	end

	// Ring entries arrive from the device
	always_ff @(posedge clk) begin
		if (link.wr_valid) begin
			ring_mem[link.wr_idx[hrc_pkg::RING_AW-1:0]] <= link.wr_data;
		end
	end

	// Configuration and pop pulse
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg_q <= hrc_pkg::CFG_RST;
			consume_q <= 1'h0;
		end else begin
			cfg_q <= cfg_d;
			consume_q <= pop;
		end
	end

	// Bus handshake: one wait state per transfer
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ph_q <= 1'h0;
			ph_wr_q <= 1'h0;
			ph_addr_q <= 4'h0;
			hreadyout_q <= 1'h1;
			hrdata_q <= 32'h00000000;
		end else if (ph_q) begin
			ph_q <= 1'h0;
			hreadyout_q <= 1'h1;
			hrdata_q <= ph_wr_q ? 32'h00000000 : rdata_d;
		end else if (accept) begin
			ph_q <= 1'h1;
			ph_wr_q <= hwrite;
			ph_addr_q <= haddr[3:0];
			hreadyout_q <= 1'h0;
		end
	end

	// Outputs
	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = hrc_pkg::HRESP_OKAY;
	assign link.ctl_depth = cfg_q[7:0];
	assign link.ctl_rdy = cfg_q[hrc_pkg::CFG_RDY_BIT];
	assign link.ctl_rst_n = ~cfg_q[hrc_pkg::CFG_RST_BIT];
	assign link.ctl_consume = consume_q;
endmodule
`default_nettype wire

// >>> hrc_dev.sv
// Host ring control/status register and write window, device end
//
// A request/acknowledge host register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module hrc_dev (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Controller link
	hrc_if.dev link,
	// Host register port
	input wire logic host_req,
	input wire logic host_wr,
	input wire logic [3:0] host_addr,
	input wire logic [31:0] host_wdata,
	output logic host_ack,
	output logic [31:0] host_rdata
);
	// Register state
	logic [7:0] depth_q;
	logic [7:0] wr_ptr_q;
	logic [7:0] wr_ptr_d;
	logic [7:0] rd_ptr_q;
	logic [7:0] rd_ptr_d;
	logic host_reset_q;
	logic host_reset_d;
	logic host_rdy_q;
	logic host_rdy_d;
	logic rdy_block_q;
	logic rdy_block_d;
	logic ring_reset_q;
	logic wr_valid_q;
	logic [7:0] wr_idx_q;
	logic [31:0] wr_data_q;
	logic host_ack_q;
	logic [31:0] host_rdata_q;

	// Address decode
	wire hit_csr = host_req & (host_addr == hrc_pkg::OFF_CTRL_STATUS);
	wire hit_win = host_req & (host_addr == hrc_pkg::OFF_WRITE_WINDOW);
	wire csr_wr = hit_csr & host_wr;
	wire csr_rd = hit_csr & ~host_wr;

	// Ring reset request edge
	wire wr_rst_bit = host_wdata[hrc_pkg::RST_BIT];
	wire wr_rdy_bit = host_wdata[hrc_pkg::RDY_BIT];
	wire rst_rise = csr_wr & wr_rst_bit & ~host_reset_q;

	// Controller readiness as seen by the window
	wire ctl_rdy_eff = link.ctl_rdy & ~rdy_block_q;
	wire win_accept = hit_win & host_wr & ctl_rdy_eff;

	// Pointer wrap mask from the one-hot depth
	wire [7:0] ptr_mask = depth_q - 8'h01;
	wire [7:0] wr_ptr_inc = (wr_ptr_q + 8'h01) & ptr_mask;
	wire [7:0] rd_ptr_inc = (rd_ptr_q + 8'h01) & ptr_mask;

	// Read value of the control/status word
	wire [31:0] csr_val = {depth_q, wr_ptr_q, rd_ptr_q, hrc_pkg::RSVD_VAL,
		host_reset_q, host_rdy_q, hrc_pkg::IRQ_FIELD_VAL};
	wire [31:0] rdata_d = csr_rd ? csr_val : 32'h00000000;

	// Next-state selection
	assign wr_ptr_d = rst_rise ? hrc_pkg::PTR_RST : (win_accept ? wr_ptr_inc : wr_ptr_q);
	assign rd_ptr_d = rst_rise ? hrc_pkg::PTR_RST : (link.ctl_consume ? rd_ptr_inc : rd_ptr_q);
	assign host_reset_d = csr_wr ? wr_rst_bit : host_reset_q;
	assign host_rdy_d = rst_rise ? 1'h0 : (csr_wr ? wr_rdy_bit : host_rdy_q);
	assign rdy_block_d = rst_rise ? 1'h1 : (link.ctl_rdy ? rdy_block_q : 1'h0);

	// Keep only the highest set bit so the field never shows two depths
	logic [7:0] depth_hi;
	genvar gi;
	generate
		for (gi = 0; gi < hrc_pkg::PTR_W; gi++) begin : g_depth_bit
			wire [7:0] higher = link.ctl_depth >> (gi + 1);
			assign depth_hi[gi] = link.ctl_depth[gi] & ~(|higher);
		end
	endgenerate

	// Depth mirror, also returned to default by the controller reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			depth_q <= hrc_pkg::DEPTH_RST;
		end else if (!link.ctl_rst_n) begin
			depth_q <= hrc_pkg::DEPTH_RST;
		end else begin
			depth_q <= depth_hi;
		end
	end

	// Write pointer
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_ptr_q <= hrc_pkg::PTR_RST;
		end else begin
			wr_ptr_q <= wr_ptr_d;
		end
	end

	// Read pointer
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rd_ptr_q <= hrc_pkg::PTR_RST;
		end else begin
			rd_ptr_q <= rd_ptr_d;
		end
	end

	// Host reset request bit
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			host_reset_q <= 1'h0;
		end else begin
			host_reset_q <= host_reset_d;
		end
	end

	// Host ready bit
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			host_rdy_q <= 1'h0;
		end else begin
			host_rdy_q <= host_rdy_d;
		end
	end

	// Window block after a ring reset until the controller drops ready
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdy_block_q <= 1'h0;
		end else begin
			rdy_block_q <= rdy_block_d;
		end
	end

	// Ring reset pulse to the controller
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ring_reset_q <= 1'h0;
		end else begin
			ring_reset_q <= rst_rise;
		end
	end

	// Entry strobe to the controller ring
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_valid_q <= 1'h0;
		end else begin
			wr_valid_q <= win_accept;
		end
	end

	// Slot of the accepted entry
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_idx_q <= hrc_pkg::PTR_RST;
		end else if (win_accept) begin
			wr_idx_q <= wr_ptr_q;
		end
	end

	// Word of the accepted entry
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_data_q <= 32'h00000000;
		end else if (win_accept) begin
			wr_data_q <= host_wdata;
		end
	end

	// Host acknowledge
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			host_ack_q <= 1'h0;
		end else begin
			host_ack_q <= host_req;
		end
	end

	// Host read data
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			host_rdata_q <= 32'h00000000;
		end else begin
			host_rdata_q <= rdata_d;
		end
	end

	// Outputs
	assign host_ack = host_ack_q;
	assign host_rdata = host_rdata_q;
	assign link.wr_ptr = wr_ptr_q;
	assign link.rd_ptr = rd_ptr_q;
	assign link.host_rdy = host_rdy_q;
	assign link.ring_reset = ring_reset_q;
	assign link.wr_valid = wr_valid_q;
	assign link.wr_idx = wr_idx_q;
	assign link.wr_data = wr_data_q;
endmodule
`default_nettype wire

// >>> hrc_if.sv
// Link between the host ring register block and the embedded controller
`timescale 1ns/1ps
`default_nettype none
interface hrc_if (
	input wire logic clk,
	input wire logic nrst
);
	// Controller to device
	logic [7:0] ctl_depth;
	logic ctl_rst_n;
	logic ctl_rdy;
	logic ctl_consume;
	// Device to controller
	logic [7:0] wr_ptr;
	logic [7:0] rd_ptr;
	logic host_rdy;
	logic ring_reset;
	logic wr_valid;
	logic [7:0] wr_idx;
	logic [31:0] wr_data;

	modport dev (
		input ctl_depth, ctl_rst_n, ctl_rdy, ctl_consume,
		output wr_ptr, rd_ptr, host_rdy, ring_reset, wr_valid, wr_idx, wr_data
	);
	modport ctl (
		output ctl_depth, ctl_rst_n, ctl_rdy, ctl_consume,
		input wr_ptr, rd_ptr, host_rdy, ring_reset, wr_valid, wr_idx, wr_data
	);
endinterface
`default_nettype wire

// >>> hrc_pkg.sv
// Shared constants for the host ring control/status block and its controller end
`default_nettype none
package hrc_pkg;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned PTR_W = 8;
	localparam int unsigned RING_MAX = 128;
	localparam int unsigned RING_AW = 7;
	// Host-side register offsets
	localparam logic [3:0] OFF_WRITE_WINDOW = 4'h0;
	localparam logic [3:0] OFF_CTRL_STATUS = 4'h4;
	// Host control/status field positions
	localparam int unsigned DEPTH_LSB = 24;
	localparam int unsigned WPTR_LSB = 16;
	localparam int unsigned RPTR_LSB = 8;
	localparam int unsigned RST_BIT = 4;
	localparam int unsigned RDY_BIT = 3;
	// Reset values
	localparam logic [7:0] DEPTH_RST = 8'h02;
	localparam logic [7:0] PTR_RST = 8'h00;
	localparam logic [2:0] RSVD_VAL = 3'h0;
	localparam logic [2:0] IRQ_FIELD_VAL = 3'h0;
	localparam logic [31:0] CSR_RST = 32'h02000000;
	// Controller register offsets
	localparam logic [3:0] CTL_OFF_CFG = 4'h0;
	localparam logic [3:0] CTL_OFF_STAT = 4'h4;
	localparam logic [3:0] CTL_OFF_POP = 4'h8;
	localparam logic [3:0] CTL_OFF_DATA = 4'hC;
	// Controller configuration and status fields
	localparam int unsigned CFG_RDY_BIT = 8;
	localparam int unsigned CFG_RST_BIT = 9;
	localparam int unsigned STAT_HRDY_BIT = 16;
	localparam logic [9:0] CFG_RST = 10'h002;
	// AHB-Lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'h0;
endpackage
`default_nettype wire

// >>> hrc_properties.sv
// Link checks between the host ring register block and the controller end
`timescale 1ns/1ps
`default_nettype none
module hrc_properties (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Controller to device
	input wire logic [7:0] ctl_depth,
	input wire logic ctl_rst_n,
	input wire logic ctl_rdy,
	input wire logic ctl_consume,
	// Device to controller
	input wire logic [7:0] wr_ptr,
	input wire logic [7:0] rd_ptr,
	input wire logic host_rdy,
	input wire logic ring_reset,
	input wire logic wr_valid,
	input wire logic [7:0] wr_idx,
	input wire logic [31:0] wr_data
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	property p_wr_step;
		wr_valid && ctl_rst_n && $stable(ctl_depth) |-> wr_ptr == ((wr_idx + 8'h01) & (ctl_depth - 8'h01));
	endproperty
	a_wr_step: assert property (p_wr_step) else $error("write pointer step wrong");
	property p_wr_idx;
		wr_valid |-> wr_idx == $past(wr_ptr);
	endproperty
	a_wr_idx: assert property (p_wr_idx) else $error("write slot index wrong");
	property p_wr_gate;
		wr_valid |-> $past(ctl_rdy);
	endproperty
	a_wr_gate: assert property (p_wr_gate) else $error("write passed while controller not ready");
	property p_wp_hold;
		!wr_valid && !ring_reset |-> $stable(wr_ptr);
	endproperty
	a_wp_hold: assert property (p_wp_hold) else $error("write pointer moved without a write");
	property p_rst_ptr;
		ring_reset |-> wr_ptr == 8'h00 && rd_ptr == 8'h00;
	endproperty
	a_rst_ptr: assert property (p_rst_ptr) else $error("ring reset left pointers set");
	property p_rst_rdy;
		ring_reset |=> !host_rdy && !ctl_rdy;
	endproperty
	a_rst_rdy: assert property (p_rst_rdy) else $error("ring reset left a ready flag set");
	property p_pulse;
		ring_reset |=> !ring_reset;
	endproperty
	a_pulse: assert property (p_pulse) else $error("ring reset pulse too long");
	property p_rd_step;
		ctl_consume && ctl_rst_n |=> ring_reset || rd_ptr == (($past(rd_ptr) + 8'h01) & ($past(ctl_depth) - 8'h01));
	endproperty
	a_rd_step: assert property (p_rd_step) else $error("read pointer step wrong");
	property p_rp_hold;
		!ctl_consume |=> ring_reset || $stable(rd_ptr);
	endproperty
	a_rp_hold: assert property (p_rp_hold) else $error("read pointer moved without a consume");
endmodule
`default_nettype wire

// >>> hrc_tb_top.sv
// Testbench joining both ends of the host ring link
`timescale 1ns/1ps
`default_nettype none
module hrc_tb_top;
	typedef struct packed {logic ahb; logic w; logic [3:0] a; logic [31:0] d; logic [31:0] e;} hrc_row_t;
	logic clk, nrst, h_req, h_wr, h_ack, hsel, hwrite, hreadyout, hresp;
	logic [3:0] h_addr;
	logic [1:0] htrans;
	logic [31:0] h_wdata, h_rdata, haddr, hwdata, hrdata, rd;
	int fail_count, samples_checked, cyc;
	hrc_row_t rows [24] = '{'{0, 0, 0, 0, 0}, '{0, 0, 4, 0, 32'h02000000}, '{1, 1, 0, 32'h108, 0},
		'{0, 0, 4, 0, 32'h08000000}, '{0, 1, 0, 32'hA1, 0}, '{0, 1, 0, 32'hB2, 0}, '{0, 1, 4, 32'h08, 0},
		'{0, 0, 4, 0, 32'h08020008}, '{1, 0, 4, 0, 32'h00010002}, '{1, 0, 12, 0, 32'hA1}, '{1, 1, 8, 0, 0},
		'{0, 0, 4, 0, 32'h08020108}, '{0, 1, 4, 32'h18, 0}, '{0, 0, 4, 0, 32'h08000010}, '{1, 0, 0, 0, 32'h8},
		'{1, 0, 4, 0, 0}, '{0, 1, 0, 32'hC3, 0}, '{0, 0, 4, 0, 32'h08000010}, '{1, 1, 0, 32'h208, 0},
		'{0, 0, 4, 0, 32'h02000010}, '{1, 1, 0, 32'h104, 0}, '{0, 0, 4, 0, 32'h04000010},
		'{1, 1, 8, 0, 0}, '{1, 0, 4, 0, 32'h00000000}};
	hrc_if hrc_if_inst (.clk(clk), .nrst(nrst));
	hrc_dev hrc_dev_inst (.clk(clk), .nrst(nrst), .link(hrc_if_inst), .host_req(h_req), .host_wr(h_wr),
		.host_addr(h_addr), .host_wdata(h_wdata), .host_ack(h_ack), .host_rdata(h_rdata));
	hrc_ctl hrc_ctl_inst (.clk(clk), .nrst(nrst), .link(hrc_if_inst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp));
	hrc_properties hrc_properties_inst (.clk(clk), .nrst(nrst), .ctl_depth(hrc_if_inst.ctl_depth),
		.ctl_rst_n(hrc_if_inst.ctl_rst_n), .ctl_rdy(hrc_if_inst.ctl_rdy), .ctl_consume(hrc_if_inst.ctl_consume),
		.wr_ptr(hrc_if_inst.wr_ptr), .rd_ptr(hrc_if_inst.rd_ptr), .host_rdy(hrc_if_inst.host_rdy),
		.ring_reset(hrc_if_inst.ring_reset), .wr_valid(hrc_if_inst.wr_valid), .wr_idx(hrc_if_inst.wr_idx),
		.wr_data(hrc_if_inst.wr_data));
	task automatic stop_test;
		$display("Compared %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", n, e, g);
			fail_count++;
		end
	endtask
	task automatic host(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		h_req <= 1'b1;
		h_wr <= w;
		h_addr <= a;
		h_wdata <= d;
		@(posedge clk);
		h_req <= 1'b0;
		do @(posedge clk); while (h_ack !== 1'b1);
		rd = h_rdata;
	endtask
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= hrc_pkg::HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc > 3000) begin
			fail_count++;
			stop_test;
		end
	end
	initial begin
		{nrst, h_req, h_wr, h_addr, h_wdata, hsel, hwrite, htrans, haddr, hwdata} = '0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		for (int i = 0; i < 24; i++) begin
			if (rows[i].ahb) ahb(rows[i].w, {28'h0, rows[i].a}, rows[i].d);
			else host(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) chk("read data", rows[i].e, rd);
			if (i == 11) chk("fill level", 32'h00000001, {24'h0, (rd[23:16] - rd[15:8]) & (rd[31:24] - 8'h01)});
		end
		// Back-to-back window writes wrap the pointer at depth 4
		@(posedge clk);
		h_req <= 1'b1;
		h_wr <= 1'b1;
		h_addr <= hrc_pkg::OFF_WRITE_WINDOW;
		for (int i = 0; i < 5; i++) begin
			h_wdata <= 32'(i);
			@(posedge clk);
		end
		h_req <= 1'b0;
		host(1'b0, hrc_pkg::OFF_CTRL_STATUS, 32'h0);
		chk("wrapped pointer", 32'h04010010, rd);
		ahb(1'b0, 32'h0000000C, 32'h0);
		chk("ring word", 32'h00000004, rd);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		host(1'b0, hrc_pkg::OFF_CTRL_STATUS, 32'h0);
		chk("status after reset", hrc_pkg::CSR_RST, rd);
		stop_test;
	end
endmodule
`default_nettype wire
